/* File: verilog/bitop_pkg.sv */
// constants for the bit set / bit test skip execution unit
// assumes a core that feeds one decoded program word per instruction cycle
// Notes on behaviour
// [RULE1] access flag zero uses access bank, else bank select
// [RULE2] extended set, access zero, f up to 95 indexes
// [RULE3] prefix 1011 skips on clear, 1010 on set
// [RULE4] skip flushes prefetched word, executes nop instead
// [RULE5] prefix 1000 sets chosen bit of byte
// [RULE6] bit set completes in one cycle, read-modify-write; here the write closes on the edge that ends the cycle after decode
package bitop_pkg;
  localparam logic [3:0]  OP_BIT_SET       = 4'h8;
  localparam logic [3:0]  OP_SKIP_IF_CLEAR = 4'hb;
  localparam logic [3:0]  OP_SKIP_IF_SET   = 4'ha;
  localparam logic [7:0]  INDEXED_LIMIT    = 8'h5f;
  localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
  localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0]  BANK_RESET       = 4'h0;
  localparam logic [11:0] ADDR_RESET       = 12'h000;
  localparam logic [7:0]  DATA_RESET       = 8'h00;
  localparam int          BANK_W           = 4;
  localparam int          ADDR_W           = 12;
  localparam int          DEPTH            = 4096;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_FLUSH = 2'b01
  } exec_state_t;
endpackage

/* File: verilog/data_mem.sv */
// byte-wide data memory, one write port, registered read port
// assumes a single clock; read data appears the edge after the address
`timescale 1ns/1ps
module data_mem
  import bitop_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic          core_clk,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: verilog/bitop_exec.sv */
// execution unit for bit set, test-skip-if-clear and test-skip-if-set
// assumes one instruction word per cycle when instr_valid; each cycle is one
// instruction cycle; the memory read is registered, so the word is decoded
// in its cycle and read-modify-write closes on the edge that ends the next cycle
`timescale 1ns/1ps
module bitop_exec
  import bitop_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic        ext_set_en,
  input  wire logic [11:0] index_base,
  input  wire logic        bank_load,
  input  wire logic [11:0] load_addr,
  input  wire logic [7:0]  load_data,
  output logic             flush_prefetch,
  output logic             nop_exec,
  output logic             done,
  output logic             skip_taken,
  output logic [7:0]       result_byte,
  output logic [11:0]      result_addr
);
  exec_state_t state_r, state_nxt;
  logic [3:0]  op_r, op_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic        pend_r, pend_nxt;
  logic        flush_r, flush_nxt;
  logic        nop_r, nop_nxt;
  logic        done_r, done_nxt;
  logic        skip_r, skip_nxt;
  logic [7:0]  res_r, res_nxt;
  logic [11:0] raddr_r, raddr_nxt;
  logic [11:0] eff_addr;
  logic [7:0]  rd_data;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [7:0]  wr_data;
  logic [3:0]  opc;
  logic        acc;
  logic [7:0]  fld;
  logic        bitv;

  logic [7:0]  bit_sel;
  logic        skip_now;
  logic        known_op;

  assign opc = instr_word[15:12];
  assign acc = instr_word[8];
  assign fld = instr_word[7:0];
  assign known_op = (opc == OP_BIT_SET) || (opc == OP_SKIP_IF_CLEAR) || (opc == OP_SKIP_IF_SET);

  // operand address selection
  always_comb begin
    if (!acc) begin
      if (ext_set_en && (fld <= INDEXED_LIMIT)) begin                   // [RULE2]
        eff_addr = index_base + {4'h0, fld};
      end else if (fld < ACCESS_SPLIT) begin                             // [RULE1]
        eff_addr = {BANK_RESET, fld};
      end else begin
        eff_addr = {ACCESS_HIGH_BANK, fld};
      end
    end else begin
      eff_addr = {bank_select_register, fld};                            // [RULE1]
    end
  end

  // one-hot select of the bit under test, one term per bit
  for (genvar g = 0; g < 8; g++) begin : g_bit_sel
    assign bit_sel[g] = (bit_r == 3'(g));
  end

  assign bitv = |(rd_data & bit_sel);

  // skip decision for the test word resolving this cycle
  always_comb begin
    skip_now = 1'b0;
    if (pend_r) begin
      case (op_r)
        OP_SKIP_IF_CLEAR: begin
          skip_now = !bitv;                                              // [RULE3]
        end
        OP_SKIP_IF_SET: begin
          skip_now = bitv;                                               // [RULE3]
        end
        default: begin
          skip_now = 1'b0;
        end
      endcase
    end
  end

  // bit set write back in the cycle following decode
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = addr_r;
    wr_data = rd_data;
    if (bank_load) begin
      wr_en   = 1'b1;
      wr_addr = load_addr;
      wr_data = load_data;
    end else if (pend_r && (op_r == OP_BIT_SET)) begin
      wr_en   = 1'b1;                                                    // [RULE6]
      wr_data = rd_data | (8'h01 << bit_r);                              // [RULE5]
    end
  end

  data_mem #(
    .AW(ADDR_W)
  ) u_mem (
    .core_clk (core_clk),
    .rd_addr  (eff_addr),
    .rd_data  (rd_data),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data)
  );

  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    bit_nxt   = bit_r;
    addr_nxt  = addr_r;
    pend_nxt  = 1'b0;
    flush_nxt = 1'b0;
    nop_nxt   = 1'b0;
    done_nxt  = 1'b0;
    skip_nxt  = 1'b0;
    res_nxt   = res_r;
    raddr_nxt = raddr_r;
    // resolve the instruction decoded last cycle
    if (pend_r) begin
      done_nxt = 1'b1;
      case (op_r)
        OP_BIT_SET: begin
          res_nxt   = wr_data;                                           // [RULE5]
          raddr_nxt = addr_r;
        end
        OP_SKIP_IF_CLEAR: begin
          if (!bitv) begin                                               // [RULE3]
            skip_nxt  = 1'b1;
            flush_nxt = 1'b1;                                            // [RULE4]
            state_nxt = ST_FLUSH;
          end
        end
        OP_SKIP_IF_SET: begin
          if (bitv) begin                                                // [RULE3]
            skip_nxt  = 1'b1;
            flush_nxt = 1'b1;                                            // [RULE4]
            state_nxt = ST_FLUSH;
          end
        end
        default: begin
          done_nxt = 1'b0;
        end
      endcase
    end
    case (state_r)
      ST_RUN: begin
        // prefetched word is dropped while a skip is being resolved
        if (instr_valid && !skip_now) begin                              // [RULE4]
          if (known_op) begin
            pend_nxt = 1'b1;
            op_nxt   = opc;
            bit_nxt  = instr_word[11:9];
            addr_nxt = eff_addr;
          end
        end
      end
      ST_FLUSH: begin
        // the skipped slot runs as the nop; the next word is taken as usual
        if (instr_valid && known_op) begin
          pend_nxt = 1'b1;
          op_nxt   = opc;
          bit_nxt  = instr_word[11:9];
          addr_nxt = eff_addr;
        end
        nop_nxt   = 1'b1;                                                // [RULE4]
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // pipeline group: decoded word waiting for its operand
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_RUN;
      op_r    <= 4'h0;
      bit_r   <= 3'h0;
      addr_r  <= ADDR_RESET;
      pend_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      bit_r   <= bit_nxt;
      addr_r  <= addr_nxt;
      pend_r  <= pend_nxt;
    end
  end

  // report group: one-cycle pulses and the last bit set result
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flush_r <= 1'b0;
      nop_r   <= 1'b0;
      done_r  <= 1'b0;
      skip_r  <= 1'b0;
      res_r   <= DATA_RESET;
      raddr_r <= ADDR_RESET;
    end else begin
      flush_r <= flush_nxt;
      nop_r   <= nop_nxt;
      done_r  <= done_nxt;
      skip_r  <= skip_nxt;
      res_r   <= res_nxt;
      raddr_r <= raddr_nxt;
    end
  end

  assign flush_prefetch = flush_r;
  assign nop_exec       = nop_r;
  assign done           = done_r;
  assign skip_taken     = skip_r;
  assign result_byte    = res_r;
  assign result_addr    = raddr_r;
endmodule

/* File: tb/fetch_model.sv */
// fetch side model: counts prefetched words thrown away
// assumes flush_prefetch is a one-cycle pulse
`timescale 1ns/1ps
module fetch_model (
  input  wire logic core_clk,
  input  wire logic flush_prefetch,
  output int        dropped
);
  initial dropped = 0;
  always @(posedge core_clk) begin
    if (flush_prefetch === 1'b1) dropped <= dropped + 1;
  end
endmodule

/* File: tb/bitop_exec_props.sv */
// checker on the execution unit's ports
// assumes one clock and asynchronous active-low reset
`timescale 1ns/1ps
module bitop_exec_props
  import bitop_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        flush_prefetch,
  input wire logic        nop_exec,
  input wire logic        done,
  input wire logic        skip_taken
);
  wire  set_w = instr_valid && instr_word[15:12] == OP_BIT_SET;
  wire  tst_w = instr_valid && instr_word[15:13] == 3'h5;
  logic tst_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) tst_r <= 1'b0;
    else tst_r <= tst_w;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_set_done: assert property (set_w && !tst_r |-> ##2 done && !skip_taken)
    else $error("bit set did not finish");
  a_test_done: assert property (tst_w && !tst_r |-> ##2 done)
    else $error("bit test did not finish");
  a_skip_pair: assert property (skip_taken |-> flush_prefetch && done)
    else $error("skip without flush");
  a_nop_follow: assert property (flush_prefetch |=> nop_exec)
    else $error("no nop after flush");
  a_nop_cause: assert property (nop_exec |-> $past(flush_prefetch))
    else $error("nop without flush");
  a_flush_cause: assert property (flush_prefetch |-> $past(tst_w, 2))
    else $error("flush without test");
  a_done_cause: assert property (done |-> $past(set_w || tst_w, 2))
    else $error("done without instruction");
  c_set: cover property (set_w);
  c_skip: cover property (skip_taken);
  c_nop: cover property (nop_exec);
endmodule
bind bitop_exec bitop_exec_props u_props (.core_clk, .arst_n, .instr_valid, .instr_word,
  .flush_prefetch, .nop_exec, .done, .skip_taken);

/* File: tb/tb_bit_set_and_bit_test_skip.sv */
// self-checking bench for the bit set and bit test skip unit
// assumes inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_bit_set_and_bit_test_skip;
  import bitop_pkg::*;
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, v); end end
  logic        core_clk = 0, arst_n = 0, instr_valid = 0, ext_set_en = 0, bank_load = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0]  bank_select_register = 4'h3;
  logic [11:0] index_base = 12'h200, load_addr = 12'h000, result_addr;
  logic [7:0]  load_data = 8'h00, result_byte;
  logic        flush_prefetch, nop_exec, done, skip_taken;
  int          error_cnt = 0, compares = 0, dropped;
  bitop_exec dut (.core_clk(core_clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .bank_select_register(bank_select_register), .ext_set_en(ext_set_en),
    .index_base(index_base), .bank_load(bank_load), .load_addr(load_addr), .load_data(load_data),
    .flush_prefetch(flush_prefetch), .nop_exec(nop_exec), .done(done), .skip_taken(skip_taken),
    .result_byte(result_byte), .result_addr(result_addr));
  fetch_model fm (.core_clk(core_clk), .flush_prefetch(flush_prefetch), .dropped(dropped));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic load(input logic [11:0] a, input logic [7:0] d);
    bank_load = 1; load_addr = a; load_data = d;
    @(posedge core_clk); #1 bank_load = 0;
  endtask
  task automatic run(input logic [15:0] w);
    instr_valid = 1; instr_word = w;
    @(posedge core_clk); #1 instr_valid = 0;
    @(posedge core_clk); #1;
  endtask
  task automatic t_set();
    load(12'h305, 8'h0a); run(16'h8f05);
    `CHK("done", 1'b1, done)
    `CHK("byte", 8'h8a, result_byte)
    `CHK("addr", 12'h305, result_addr)
  endtask
  task automatic t_addr();
    load(12'hf80, 8'h00); run(16'h8680);
    `CHK("acc addr", 12'hf80, result_addr)
    `CHK("acc byte", 8'h08, result_byte)
    ext_set_en = 1; load(12'h25f, 8'h01); run(16'h825f);
    `CHK("idx addr", 12'h25f, result_addr)
    `CHK("idx byte", 8'h03, result_byte)
    run(16'h8060);
    `CHK("edge addr", 12'hf60, result_addr)
    run(16'h8110);
    `CHK("bank addr", 12'h310, result_addr)
    ext_set_en = 0;
    load(12'h05f, 8'h80); run(16'h805f);
    `CHK("low addr", 12'h05f, result_addr)
    `CHK("low byte", 8'h81, result_byte)
  endtask
  task automatic t_skip();
    logic e;
    load(12'h310, 8'h04);
    for (int i = 0; i < 4; i++) begin
      e = ((i < 2) == i[0]);
      run({(i < 2) ? OP_SKIP_IF_CLEAR : OP_SKIP_IF_SET, i[0] ? 3'd3 : 3'd2, 1'b1, 8'h10});
      `CHK("skip", e, skip_taken)
      `CHK("flush", e, flush_prefetch)
      `CHK("test done", 1'b1, done)
      @(posedge core_clk); #1;
      `CHK("nop", e, nop_exec)
    end
    `CHK("dropped", 2, dropped)
  endtask
  task automatic t_drop();
    load(12'h320, 8'h01);
    instr_valid = 1; instr_word = 16'ha120;
    @(posedge core_clk); #1 instr_word = 16'h8f20;
    @(posedge core_clk); #1 instr_word = 16'h8d20;
    `CHK("drop skip", 1'b1, skip_taken)
    `CHK("drop flush", 1'b1, flush_prefetch)
    @(posedge core_clk); #1 instr_valid = 0;
    `CHK("drop nop", 1'b1, nop_exec)
    `CHK("drop done", 1'b0, done)
    @(posedge core_clk); #1;
    `CHK("next done", 1'b1, done)
    `CHK("next byte", 8'h41, result_byte)
    `CHK("next addr", 12'h320, result_addr)
    `CHK("drop count", 3, dropped)
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 arst_n = 1;
    t_set();
    t_addr();
    t_skip();
    t_drop();
    end_of_test();
  end
endmodule
